//--- imt_regs_top.sv
// Top: interrupt mask registers, internal temperature offset and measured value
//
// Behaviour
// - Mask-four bit 0 set keeps internal temperature events from raising the request.
// - Mask-four bits 1 and 2 set keep battery and analog input 8 events from the request.
// - Mask-four bit 3 set keeps thermal alarm events from raising the request.
// - Mask-four bit 4 set keeps automatic fan control events from raising the request.
// - Mask-four bit 5 has no function and always reads zero.
// - Mask-four bit 6 set keeps chassis intrusion events from raising the request.
// - Mask-four bit 7 set keeps general pin 16 events from raising the request.
// - Bit n of the low pin mask set keeps general pin n events from the request.
// - Bit n of the high pin mask set keeps general pin n plus 8 events from the request.
// - The signed offset is added to the raw temperature before storing and comparing.
// - The corrected temperature reads from a read-only register that ignores writes.
// - Reset clears every register of the block to zero.
// - The temperature flag is one when the last result lay above high or below low limit.
`timescale 1ns/10ps
`default_nettype none
module imt_regs_top
   import imt_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = IMT_SLAVE_ADDR_DEF
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE,
   input  wire logic [7:0]  TEMP_RAW,
   input  wire logic        TEMP_CONV_DONE,
   input  wire logic [7:0]  TEMP_HIGH_LIMIT,
   input  wire logic [7:0]  TEMP_LOW_LIMIT,
   input  wire logic [23:0] CHAN_FLAGS,
   output logic [7:0]       TEMP_VALUE,
   output logic             TEMP_STATUS,
   output logic             IRQ_REQ
);
   imt_reg_if rif ();

   logic [7:0]  mask_four_q, mask_four_d;
   logic [7:0]  pin_mask_lo_q, pin_mask_lo_d;
   logic [7:0]  pin_mask_hi_q, pin_mask_hi_d;
   logic [7:0]  temp_ofs_q, temp_ofs_d;
   logic [7:0]  temp_val_q, temp_val_d;
   logic        temp_stat_q, temp_stat_d;
   logic        irq_q, irq_d;
   logic [7:0]  corrected;
   logic [23:0] flag_vec;
   logic [23:0] mask_vec;

   // Saturating signed add so a large offset cannot wrap hot into cold
   function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {a[7], a} + {b[7], b};
      if (s[8] != s[7]) sat_add = s[8] ? IMT_TEMP_MIN : IMT_TEMP_MAX;
      else sat_add = s[7:0];
   endfunction

   function automatic logic out_of_limits(input logic [7:0] v, input logic [7:0] hi,
                                          input logic [7:0] lo);
      out_of_limits = ($signed(v) > $signed(hi)) || ($signed(v) < $signed(lo));
   endfunction

   imt_smbus_slave #(
      .SLAVE_ADDR (SLAVE_ADDR)
   ) u_slave (
      .clk    (SYS_CLK),
      .rst    (RST),
      .scl_in (SCL_IN),
      .sda_in (SDA_IN),
      .sda_oe (SDA_OE),
      .regs   (rif.bus)
   );

   // Open-drain: the pin is only ever pulled low
   assign SDA_OUT = 1'b0;

   assign corrected = sat_add(TEMP_RAW, temp_ofs_q);

   // Temperature flag is ours; the other channels arrive as flags, bits 0 and 5 ignored
   assign flag_vec = {CHAN_FLAGS[23:6], 1'b0, CHAN_FLAGS[4:1], temp_stat_q};
   assign mask_vec = {pin_mask_hi_q, pin_mask_lo_q, mask_four_q};

   always_comb begin
      mask_four_d   = mask_four_q;
      pin_mask_lo_d = pin_mask_lo_q;
      pin_mask_hi_d = pin_mask_hi_q;
      temp_ofs_d    = temp_ofs_q;
      temp_val_d    = temp_val_q;
      temp_stat_d   = temp_stat_q;
      if (rif.wr_stb) begin
         case (rif.addr)
            IMT_OFS_EVENT_MASK_FOUR: begin
               mask_four_d = rif.wdata & IMT_MASK_FOUR_WRITABLE;
            end
            IMT_OFS_PIN_EVENT_MASK_LOW:  pin_mask_lo_d = rif.wdata;
            IMT_OFS_PIN_EVENT_MASK_HIGH: pin_mask_hi_d = rif.wdata;
            IMT_OFS_INTERNAL_TEMP_OFS:   temp_ofs_d = rif.wdata;
            default:                     temp_ofs_d = temp_ofs_q;
         endcase
      end
      if (TEMP_CONV_DONE) begin
         temp_val_d  = corrected;
         temp_stat_d = out_of_limits(corrected, TEMP_HIGH_LIMIT, TEMP_LOW_LIMIT);
      end
      // Mask gates only the request; flag_vec itself is never touched
      irq_d = |(flag_vec & ~mask_vec);
   end

   always_comb begin
      case (rif.addr)
         IMT_OFS_EVENT_MASK_FOUR:     rif.rdata = mask_four_q;
         IMT_OFS_PIN_EVENT_MASK_LOW:  rif.rdata = pin_mask_lo_q;
         IMT_OFS_PIN_EVENT_MASK_HIGH: rif.rdata = pin_mask_hi_q;
         IMT_OFS_INTERNAL_TEMP_OFS:   rif.rdata = temp_ofs_q;
         IMT_OFS_INTERNAL_TEMP_VALUE: rif.rdata = temp_val_q;
         default:                     rif.rdata = IMT_UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         mask_four_q   <= IMT_RST_VALUE;
         pin_mask_lo_q <= IMT_RST_VALUE;
         pin_mask_hi_q <= IMT_RST_VALUE;
         temp_ofs_q    <= IMT_RST_VALUE;
         temp_val_q    <= IMT_RST_VALUE;
         temp_stat_q   <= 1'b0;
         irq_q         <= 1'b0;
      end else begin
         mask_four_q   <= mask_four_d;
         pin_mask_lo_q <= pin_mask_lo_d;
         pin_mask_hi_q <= pin_mask_hi_d;
         temp_ofs_q    <= temp_ofs_d;
         temp_val_q    <= temp_val_d;
         temp_stat_q   <= temp_stat_d;
         irq_q         <= irq_d;
      end
   end

   assign TEMP_VALUE  = temp_val_q;
   assign TEMP_STATUS = temp_stat_q;
   assign IRQ_REQ     = irq_q;

   int_temp_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flag_vec == 24'h000001) && mask_four_q[IMT_BIT_INT_TEMP] |=> !IRQ_REQ)
      else $error("internal temperature event passed its mask");

   batt_ain_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      ((flag_vec & ~24'h000006) == 24'h0)
      |=> IRQ_REQ == |($past(flag_vec[2:1]) & ~$past(mask_four_q[2:1])))
      else $error("battery or analog 8 request mismatch");

   thermal_alarm_event_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flag_vec == 24'h000008) |=> IRQ_REQ == !$past(mask_four_q[IMT_BIT_THERMAL_ALARM]))
      else $error("thermal alarm request mismatch");

   fan_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flag_vec == 24'h000010) |=> IRQ_REQ == !$past(mask_four_q[IMT_BIT_AUTO_FAN]))
      else $error("fan control request mismatch");

   unused_bit_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      rif.wr_stb && rif.addr == IMT_OFS_EVENT_MASK_FOUR |=> !mask_four_q[IMT_BIT_UNUSED])
      else $error("unused mask bit reads one");

   chassis_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flag_vec == 24'h000040) |=> IRQ_REQ == !$past(mask_four_q[IMT_BIT_CHASSIS]))
      else $error("chassis intrusion request mismatch");

   pin16_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flag_vec == 24'h000080) |=> IRQ_REQ == !$past(mask_four_q[IMT_BIT_GENERAL_PIN_16]))
      else $error("general pin 16 request mismatch");

   pin_low_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flag_vec[23:16] == 8'h00) && (flag_vec[7:0] == 8'h00)
      |=> IRQ_REQ == |($past(flag_vec[15:8]) & ~$past(pin_mask_lo_q)))
      else $error("low pin group request mismatch");

   pin_high_mask_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      (flag_vec[15:0] == 16'h0000)
      |=> IRQ_REQ == |($past(flag_vec[23:16]) & ~$past(pin_mask_hi_q)))
      else $error("high pin group request mismatch");

   temp_store_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      TEMP_CONV_DONE |=> TEMP_VALUE == sat_add($past(TEMP_RAW), $past(temp_ofs_q)))
      else $error("stored temperature lacks offset");

   value_ro_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      rif.wr_stb && rif.addr == IMT_OFS_INTERNAL_TEMP_VALUE && !TEMP_CONV_DONE
      |=> $stable(TEMP_VALUE))
      else $error("write changed the measured value");

   reset_zero_a: assert property (@(posedge SYS_CLK)
      !RST && $past(RST) |-> mask_vec == 24'h0 && temp_ofs_q == 8'h00 &&
                             TEMP_VALUE == 8'h00 && !TEMP_STATUS && !IRQ_REQ)
      else $error("register not zero after reset");

   temp_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      TEMP_CONV_DONE |=> TEMP_STATUS == ($signed(TEMP_VALUE) > $signed($past(TEMP_HIGH_LIMIT)) ||
                                         $signed(TEMP_VALUE) < $signed($past(TEMP_LOW_LIMIT))))
      else $error("temperature flag does not follow limits");

   flag_kept_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      !TEMP_CONV_DONE ##1 rif.wr_stb |-> $stable(TEMP_STATUS))
      else $error("mask write disturbed the flag");

   readback_a: assert property (@(posedge SYS_CLK) disable iff (RST)
      rif.wr_stb && rif.addr == IMT_OFS_INTERNAL_TEMP_OFS
      |=> temp_ofs_q == $past(rif.wdata) ##1
          (temp_ofs_q == $past(temp_ofs_q) || $past(rif.wr_stb)))
      else $error("offset does not read back");
endmodule
`default_nettype wire

//--- imt_pkg.sv
// Package: register map, reset values, field positions and bus states for the mask/temp block
package imt_pkg;
   localparam logic [7:0] IMT_OFS_EVENT_MASK_FOUR     = 8'h1b;
   localparam logic [7:0] IMT_OFS_PIN_EVENT_MASK_LOW  = 8'h1c;
   localparam logic [7:0] IMT_OFS_PIN_EVENT_MASK_HIGH = 8'h1d;
   localparam logic [7:0] IMT_OFS_INTERNAL_TEMP_OFS   = 8'h1e;
   localparam logic [7:0] IMT_OFS_INTERNAL_TEMP_VALUE = 8'h1f;
   localparam logic [7:0] IMT_RST_VALUE               = 8'h00;
   localparam logic [7:0] IMT_UNMAPPED_READ           = 8'h00;
   // Writable bits of the fourth mask register; bit 5 is unused
   localparam logic [7:0] IMT_MASK_FOUR_WRITABLE      = 8'hdf;
   localparam int         IMT_BIT_INT_TEMP            = 0;
   localparam int         IMT_BIT_BATTERY             = 1;
   localparam int         IMT_BIT_ANALOG_8            = 2;
   localparam int         IMT_BIT_THERMAL_ALARM       = 3;
   localparam int         IMT_BIT_AUTO_FAN            = 4;
   localparam int         IMT_BIT_UNUSED              = 5;
   localparam int         IMT_BIT_CHASSIS             = 6;
   localparam int         IMT_BIT_GENERAL_PIN_16      = 7;
   localparam int         IMT_NUM_EVENTS              = 24;
   localparam logic [6:0] IMT_SLAVE_ADDR_DEF          = 7'h2c; // Arbitrary value
   localparam logic [3:0] IMT_BITS_PER_BYTE           = 4'h8;
   localparam logic [3:0] IMT_ACK_SLOT                = 4'h9;
   localparam logic [7:0] IMT_TEMP_MAX                = 8'h7f;
   localparam logic [7:0] IMT_TEMP_MIN                = 8'h80;
   typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_CMD, BS_WDATA, BS_RDATA} imt_bus_st_t;
endpackage

//--- imt_reg_if.sv
// Interface: register access between the two-wire slave and the register file
`timescale 1ns/10ps
`default_nettype none
interface imt_reg_if;
   logic       wr_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bus  (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- imt_smbus_slave.sv
// Two-wire system management bus slave: byte write and byte read through a register pointer
`timescale 1ns/10ps
`default_nettype none
module imt_smbus_slave
   import imt_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = IMT_SLAVE_ADDR_DEF
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_oe,
   imt_reg_if.bus    regs
);
   logic [2:0]  scl_s_q;
   logic [2:0]  sda_s_q;
   logic        scl_f_q, scl_f_d, scl_p_q;
   logic        sda_f_q, sda_f_d, sda_p_q;
   imt_bus_st_t st_q, st_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [7:0]  sh_q, sh_d;
   logic [7:0]  ptr_q, ptr_d;
   logic [7:0]  wdat_q, wdat_d;
   logic        rw_q, rw_d;
   logic        oe_q, oe_d;
   logic        wr_q, wr_d;
   logic        scl_rise, scl_fall, start_c, stop_c;

   // A level counts once the second and third stages agree
   always_comb begin
      scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
      sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
   end

   assign scl_rise = scl_f_q & ~scl_p_q;
   assign scl_fall = ~scl_f_q & scl_p_q;
   assign start_c  = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
   assign stop_c   = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      ptr_d  = ptr_q;
      wdat_d = wdat_q;
      rw_d   = rw_q;
      oe_d   = oe_q;
      wr_d   = 1'b0;
      if (stop_c) begin
         st_d = BS_IDLE;
         oe_d = 1'b0;
      end else if (start_c) begin
         // Repeated start keeps the pointer so a read can follow a command byte
         st_d  = BS_ADDR;
         cnt_d = 4'h0;
         oe_d  = 1'b0;
      end else if (st_q != BS_IDLE && scl_rise) begin
         if (st_q != BS_RDATA && cnt_q < IMT_BITS_PER_BYTE) begin
            sh_d  = {sh_q[6:0], sda_f_q};
            cnt_d = cnt_q + 4'h1;
         end else if (st_q == BS_RDATA && cnt_q < IMT_BITS_PER_BYTE) begin
            cnt_d = cnt_q + 4'h1;
         end else if (st_q == BS_RDATA && cnt_q == IMT_BITS_PER_BYTE) begin
            // Master not-acknowledge ends the read
            if (sda_f_q) st_d = BS_IDLE;
            else cnt_d = IMT_ACK_SLOT;
         end
      end else if (st_q != BS_IDLE && scl_fall) begin
         if (st_q == BS_RDATA && cnt_q < IMT_BITS_PER_BYTE) begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = ~sh_q[6];
         end else if (st_q == BS_RDATA && cnt_q == IMT_BITS_PER_BYTE) begin
            oe_d = 1'b0;
         end else if (cnt_q == IMT_BITS_PER_BYTE) begin
            cnt_d = IMT_ACK_SLOT;
            oe_d  = 1'b1;
            case (st_q)
               BS_ADDR: begin
                  rw_d = sh_q[0];
                  if (sh_q[7:1] != SLAVE_ADDR) begin
                     st_d = BS_IDLE;
                     oe_d = 1'b0;
                  end
               end
               BS_CMD:   ptr_d = sh_q;
               BS_WDATA: begin
                  wr_d   = 1'b1;
                  wdat_d = sh_q;
               end
               default:  oe_d = 1'b0;
            endcase
         end else if (cnt_q == IMT_ACK_SLOT) begin
            cnt_d = 4'h0;
            if ((st_q == BS_ADDR && rw_q) || st_q == BS_RDATA) begin
               st_d = BS_RDATA;
               sh_d = regs.rdata;
               oe_d = ~regs.rdata[7];
            end else begin
               oe_d = 1'b0;
               if (st_q == BS_ADDR) st_d = BS_CMD;
               else st_d = BS_WDATA;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_f_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_f_q <= 1'b1;
         sda_p_q <= 1'b1;
         st_q    <= BS_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         ptr_q   <= 8'h00;
         wdat_q  <= 8'h00;
         rw_q    <= 1'b0;
         oe_q    <= 1'b0;
         wr_q    <= 1'b0;
      end else begin
         scl_s_q <= {scl_s_q[1:0], scl_in};
         sda_s_q <= {sda_s_q[1:0], sda_in};
         scl_f_q <= scl_f_d;
         scl_p_q <= scl_f_q;
         sda_f_q <= sda_f_d;
         sda_p_q <= sda_f_q;
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         ptr_q   <= ptr_d;
         wdat_q  <= wdat_d;
         rw_q    <= rw_d;
         oe_q    <= oe_d;
         wr_q    <= wr_d;
      end
   end

   assign sda_oe      = oe_q;
   assign regs.wr_stb = wr_q;
   assign regs.addr   = ptr_q;
   assign regs.wdata  = wdat_q;
endmodule
`default_nettype wire

//--- imt_host_model.sv
// Bus host model: two-wire master that writes and reads one register byte
`timescale 1ns/10ps
`default_nettype none
module imt_host_model
   import imt_pkg::*;
(
   input  wire logic clk,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low
);
   initial begin
      scl_out = 1'b1;
      sda_low = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Data moves only while the bus clock is low, so it never reads as a start or stop
   task automatic put_bit(input logic b);
      wait_clk(2);
      sda_low = ~b;
      wait_clk(6);
      scl_out = 1'b1;
      wait_clk(8);
      scl_out = 1'b0;
   endtask
   task automatic get_bit(output logic b);
      wait_clk(2);
      sda_low = 1'b0;
      wait_clk(6);
      scl_out = 1'b1;
      wait_clk(4);
      b = sda_in;
      wait_clk(4);
      scl_out = 1'b0;
   endtask
   task automatic start_cond();
      wait_clk(2);
      sda_low = 1'b0;
      wait_clk(6);
      scl_out = 1'b1;
      wait_clk(8);
      sda_low = 1'b1;
      wait_clk(8);
      scl_out = 1'b0;
   endtask
   task automatic stop_cond();
      wait_clk(2);
      sda_low = 1'b1;
      wait_clk(6);
      scl_out = 1'b1;
      wait_clk(8);
      sda_low = 1'b0;
      wait_clk(8);
   endtask
   task automatic send_byte(input logic [7:0] v, output logic nack);
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(nack);
   endtask
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                            input logic [7:0] data, output logic acked);
      logic a0, a1, a2;
      start_cond();
      send_byte({dev, 1'b0}, a0);
      send_byte(ptr, a1);
      send_byte(data, a2);
      stop_cond();
      acked = ~(a0 | a1 | a2);
   endtask
   // With two set the first byte is acknowledged and a second one read into again
   task automatic read_reg(input logic [7:0] ptr, input logic two, output logic [7:0] data,
                           output logic [7:0] again);
      logic a;
      start_cond();
      send_byte({IMT_SLAVE_ADDR_DEF, 1'b0}, a);
      send_byte(ptr, a);
      start_cond();
      send_byte({IMT_SLAVE_ADDR_DEF, 1'b1}, a);
      for (int i = 7; i >= 0; i--) get_bit(data[i]);
      again = data;
      if (two) begin
         put_bit(1'b0);
         for (int i = 7; i >= 0; i--) get_bit(again[i]);
      end
      // Not acknowledging ends the read
      put_bit(1'b1);
      stop_cond();
   endtask
endmodule
`default_nettype wire

//--- tb_interrupt_mask_and_internal_temp_regs.sv
// Testbench: register access, interrupt masking and internal temperature path
`timescale 1ns/10ps
`default_nettype none
module tb_interrupt_mask_and_internal_temp_regs
   import imt_pkg::*;
;
   logic        sys_clk, rst, scl, host_sda_low, sda_wire, sda_out, sda_oe;
   logic [7:0]  temp_raw, temp_high, temp_low, temp_value, rd, rd2, ptr, exp_t;
   logic        conv_done, temp_status, irq_req, ok, exp_s;
   logic [23:0] chan_flags;
   logic [7:0]  raws [5] = '{8'h10, 8'h30, 8'h81, 8'h7f, 8'he0};
   logic [7:0]  offs [5] = '{8'hfe, 8'hfe, 8'hfe, 8'h05, 8'h00};
   int          num_errors;
   int          n_compared;

   // Open-drain data line with pull-up
   assign sda_wire = ~(host_sda_low | (sda_oe & ~sda_out));

   imt_regs_top DUT (.SYS_CLK(sys_clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_wire),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TEMP_RAW(temp_raw), .TEMP_CONV_DONE(conv_done),
      .TEMP_HIGH_LIMIT(temp_high), .TEMP_LOW_LIMIT(temp_low), .CHAN_FLAGS(chan_flags),
      .TEMP_VALUE(temp_value), .TEMP_STATUS(temp_status), .IRQ_REQ(irq_req));
   imt_host_model host (.clk(sys_clk), .sda_in(sda_wire), .scl_out(scl),
      .sda_low(host_sda_low));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic wrap_up();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] v);
      host.write_reg(IMT_SLAVE_ADDR_DEF, p, v, ok);
      chk("write ack", 8'h01, {7'h00, ok});
   endtask
   task automatic rd_chk(input string what, input logic [7:0] p, input logic [7:0] exp);
      host.read_reg(p, 1'b0, rd, rd2);
      chk(what, exp, rd);
   endtask
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic conv(input logic [7:0] raw);
      @(posedge sys_clk);
      #1;
      temp_raw = raw;
      conv_done = 1'b1;
      @(posedge sys_clk);
      #1;
      conv_done = 1'b0;
   endtask
   // Saturating sum, matching the chosen clamp rather than wrap-around
   function automatic logic [7:0] corrected(input logic [7:0] raw, input logic [7:0] ofs);
      int s;
      s = int'($signed(raw)) + int'($signed(ofs));
      if (s > 127) return 8'h7f;
      if (s < -128) return 8'h80;
      return s[7:0];
   endfunction

   initial begin
      #800_000;
      num_errors++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      conv_done = 1'b0;
      chan_flags = 24'h0;
      temp_raw = 8'h00;
      temp_high = 8'h20;
      temp_low = 8'hf0;
      num_errors = 0;
      n_compared = 0;
      repeat (10) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      repeat (8) @(posedge sys_clk);
      #1;
      chk("irq after reset", 8'h00, {7'h00, irq_req});
      chk("temp value after reset", 8'h00, temp_value);
      for (int p = 8'h1b; p <= 8'h1f; p++) rd_chk("reset value", 8'(p), IMT_RST_VALUE);
      wr(IMT_OFS_EVENT_MASK_FOUR, 8'hff);
      rd_chk("mask four", IMT_OFS_EVENT_MASK_FOUR, 8'hdf);
      wr(IMT_OFS_PIN_EVENT_MASK_LOW, 8'ha5);
      wr(IMT_OFS_PIN_EVENT_MASK_HIGH, 8'h5a);
      wr(IMT_OFS_INTERNAL_TEMP_OFS, 8'h80);
      rd_chk("pin mask low", IMT_OFS_PIN_EVENT_MASK_LOW, 8'ha5);
      rd_chk("pin mask high", IMT_OFS_PIN_EVENT_MASK_HIGH, 8'h5a);
      rd_chk("temp offset", IMT_OFS_INTERNAL_TEMP_OFS, 8'h80);
      wr(IMT_OFS_INTERNAL_TEMP_VALUE, 8'h55);
      rd_chk("temp value reg", IMT_OFS_INTERNAL_TEMP_VALUE, 8'h00);
      wr(8'h30, 8'h77);
      rd_chk("unmapped", 8'h30, IMT_UNMAPPED_READ);
      host.write_reg(IMT_SLAVE_ADDR_DEF ^ 7'h01, IMT_OFS_PIN_EVENT_MASK_LOW, 8'h00, ok);
      chk("foreign address ack", 8'h00, {7'h00, ok});
      rd_chk("pin mask low kept", IMT_OFS_PIN_EVENT_MASK_LOW, 8'ha5);
      host.read_reg(IMT_OFS_PIN_EVENT_MASK_LOW, 1'b1, rd, rd2);
      chk("second read byte", 8'ha5, rd2);
      wr(IMT_OFS_PIN_EVENT_MASK_LOW, 8'hff);
      wr(IMT_OFS_PIN_EVENT_MASK_HIGH, 8'hff);
      // Each channel from bit 1 up alone: masked gives no request, clearing only its own bit gives one
      for (int i = 1; i < IMT_NUM_EVENTS; i++) begin
         if (i != IMT_BIT_UNUSED) begin
            ptr = IMT_OFS_EVENT_MASK_FOUR + 8'(i / 8);
            chan_flags = 24'h1 << i;
            settle();
            chk("masked irq", 8'h00, {7'h00, irq_req});
            wr(ptr, ~(8'h01 << (i % 8)));
            settle();
            chk("unmasked irq", 8'h01, {7'h00, irq_req});
            wr(ptr, 8'hff);
         end
      end
      // All other channels raised but masked, so the request follows the temperature flag
      chan_flags = 24'hffffff;
      wr(IMT_OFS_EVENT_MASK_FOUR, 8'hfe);
      for (int k = 0; k < 5; k++) begin
         wr(IMT_OFS_INTERNAL_TEMP_OFS, offs[k]);
         // Third and fourth results sit exactly on a limit, which must not flag
         temp_low = (k == 2) ? 8'h80 : 8'hf0;
         temp_high = (k == 3) ? 8'h7f : 8'h20;
         conv(raws[k]);
         exp_t = corrected(raws[k], offs[k]);
         exp_s = ($signed(exp_t) > $signed(temp_high)) ||
                 ($signed(exp_t) < $signed(temp_low));
         chk("temp value", exp_t, temp_value);
         chk("temp status", {7'h00, exp_s}, {7'h00, temp_status});
         @(posedge sys_clk);
         #1;
         chk("temp irq", {7'h00, exp_s}, {7'h00, irq_req});
         rd_chk("temp value reg", IMT_OFS_INTERNAL_TEMP_VALUE, exp_t);
      end
      // Only the temperature flag left standing when its mask is set
      chan_flags = 24'h0;
      wr(IMT_OFS_EVENT_MASK_FOUR, 8'hff);
      settle();
      chk("temp irq masked", 8'h00, {7'h00, irq_req});
      chk("temp status kept", 8'h01, {7'h00, temp_status});
      wrap_up();
   end
endmodule
`default_nettype wire
